/* pkg/cpwm_pkg.sv */
// Constants and types for the compare/PWM unit
// Assumes a single core clock; the CPU side drives plain control ports
package cpwm_pkg;
    localparam int                 NUM_FAST        = 8;
    localparam logic [15:0]        T2_RESET        = 16'h0000;
    localparam logic [15:0]        TIMER_MAX       = 16'hffff;
    localparam logic [15:0]        RELOAD_RESET    = 16'h0000;
    localparam logic [15:0]        COMPARE_RESET   = 16'h0000;
    localparam logic [2:0]         PRESCALE_RESET  = 3'h0;
    localparam logic [7:0]         PRESCALE_CNT0   = 8'h00;
    localparam int                 MODE_BIT        = 0;
    localparam int                 FAST_PIN0       = 0;

    typedef enum logic [0:0] {
        CPWM_MODE0,
        CPWM_MODE1
    } cpwm_mode_t;

    // Divider terminal value for select s: fosc/2^(s+1), one core clock is fosc/2
    function automatic logic [7:0] prescale_limit(input logic [2:0] sel);
        prescale_limit = 8'((9'h001 << sel) - 9'h001);
    endfunction : prescale_limit
endpackage : cpwm_pkg

/* pkg/cpwm_tick_if.sv */
// Compare timer tick and overflow carried between modules
// Assumes all users run on the core clock
interface cpwm_tick_if;
    logic        tick;
    logic        overflow;
    logic [15:0] count;
    modport timer (output tick, output overflow, output count);
    modport user  (input tick, input overflow, input count);
endinterface : cpwm_tick_if

/* src/cpwm_ctimer.sv */
// Fast compare timer with prescaler and 16-bit reload
// Assumes a synchronous active-low reset on the core clock
module cpwm_ctimer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [2:0]  clk_sel,
    input  wire logic [15:0] reload,
    cpwm_tick_if.timer       tk
);
    logic [7:0]  prescale;
    logic [15:0] count;

    assign tk.tick     = run && (prescale >= cpwm_pkg::prescale_limit(clk_sel));
    assign tk.overflow = tk.tick && (count == cpwm_pkg::TIMER_MAX);
    assign tk.count    = count;

    always_ff @(posedge clk) begin
        if (!rst_n || !run || tk.tick) begin
            prescale <= cpwm_pkg::PRESCALE_CNT0;
        end else begin
            prescale <= prescale + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= cpwm_pkg::RELOAD_RESET;
        end else if (tk.overflow) begin
            count <= reload;
        end else if (tk.tick) begin
            count <= count + 16'h0001;
        end
    end

    property p_reload_on_ovf;
        @(posedge clk) disable iff (!rst_n)
        tk.overflow |=> count == $past(reload);
    endproperty
    a_reload_on_ovf: assert property (p_reload_on_ovf) else $error("no reload");

    property p_div2_every_cycle;
        @(posedge clk) disable iff (!rst_n)
        (run && clk_sel == 3'h0 && $past(run)) |-> tk.tick;
    endproperty
    a_div2_every_cycle: assert property (p_div2_every_cycle) else $error("div2 tick");
endmodule : cpwm_ctimer

/* src/cpwm_t2.sv */
// Timer 2, free running over the full 16-bit range
// Assumes a synchronous active-low reset on the core clock
module cpwm_t2 (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  run,
    cpwm_tick_if.timer tk
);
    logic [15:0] count;

    assign tk.tick     = run;
    assign tk.overflow = run && (count == cpwm_pkg::TIMER_MAX);
    assign tk.count    = count;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= cpwm_pkg::T2_RESET;
        end else if (run) begin
            count <= count + 16'h0001;
        end
    end

    property p_wrap_to_zero;
        @(posedge clk) disable iff (!rst_n)
        tk.overflow |=> count == 16'h0000;
    endproperty
    a_wrap_to_zero: assert property (p_wrap_to_zero) else $error("t2 wrap");
endmodule : cpwm_t2

/* src/cpwm_unit.sv */
// Compare/PWM unit: timer 2 with two compare channels, fast compare bank
// Assumes CPU writes arrive as one-cycle strobes on the core clock
//
// Operation
// - Mode 0: timer overflow drives all its mode 0 compare outputs low together.
// - Mode 0: output goes high when count equals active compare latch.
// - Mode 1: software sets both edges; overflow leaves output alone.
// - Mode 1: a match copies the preloaded port latch level to the pin.
// - Every compare match sets that channel's interrupt request.
// - Each channel has its own independent request flag.
// - Timer 2 matches a and b drive two external interrupt lines.
// - Timer 2 counts zero to all-ones then overflows.
// - Compare timer has 16-bit reload and eight fosc/2..fosc/256 clocks.
// - With fosc/2 selected the compare timer steps every machine cycle.
// - On overflow the compare timer reloads and counts to all-ones.
// - Select bit n assigns fast register n to the compare timer, mode 0.
// - Enable bit n lets fast register n drive its pin.
// - Overflow request reaches CPU only with local and global enable.
// - Fast register writes are shadowed, loaded on compare timer overflow.
// - That overflow also raises a new overflow request.
// - The compare timer serves eight fast channels at once.
module cpwm_unit (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic        T2_RUN,
    input  wire logic [1:0]  T2_MODE,
    input  wire logic        T2_CMP_WR_A,
    input  wire logic        T2_CMP_WR_B,
    input  wire logic [15:0] T2_CMP_DATA,
    input  wire logic [1:0]  T2_PORT_LATCH,
    input  wire logic [1:0]  T2_IRQ_CLR,
    input  wire logic        CT_RUN,
    input  wire logic [2:0]  COMPARE_TIMER_CONTROL,
    input  wire logic [7:0]  COMPARE_TIMER_RELOAD_HIGH,
    input  wire logic [7:0]  COMPARE_TIMER_RELOAD_LOW,
    input  wire logic [7:0]  FAST_COMPARE_SELECT,
    input  wire logic [7:0]  FAST_COMPARE_OUTPUT_ENABLE,
    input  wire logic [7:0]  FAST_PORT_LATCH,
    input  wire logic [7:0]  FAST_WR_HIGH,
    input  wire logic [7:0]  FAST_WR_LOW,
    input  wire logic [7:0]  FAST_WR_DATA,
    input  wire logic [7:0]  FAST_IRQ_CLR,
    input  wire logic        COMPARE_TIMER_OVERFLOW_IRQ_ENABLE,
    input  wire logic        GLOBAL_IRQ_ENABLE,
    input  wire logic        CT_IRQ_CLR,
    output logic      [1:0]  T2_PIN,
    output logic      [7:0]  FAST_PIN,
    output logic      [7:0]  FAST_PIN_OE,
    output logic             COMPARE_IRQ_LINE_A,
    output logic             COMPARE_IRQ_LINE_B,
    output logic      [7:0]  FAST_IRQ,
    output logic             CT_OVF_FLAG,
    output logic             CT_IRQ,
    output logic      [15:0] CT_COUNT
);
    ////////////////////////////////////////////////////////////////////////////
    // Timers
    cpwm_tick_if t2_tk ();
    cpwm_tick_if ct_tk ();

    cpwm_t2 u_t2 (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .run   (T2_RUN),
        .tk    (t2_tk.timer)
    );

    cpwm_ctimer u_ct (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .run     (CT_RUN),
        .clk_sel (COMPARE_TIMER_CONTROL),
        .reload  ({COMPARE_TIMER_RELOAD_HIGH, COMPARE_TIMER_RELOAD_LOW}),
        .tk      (ct_tk.timer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Timer 2 compare channels a and b
    logic [15:0] t2_compare_reg_a;
    logic [15:0] t2_compare_reg_b;
    logic [1:0]  t2_match;
    logic [1:0]  t2_irq;

    assign t2_match[0] = t2_tk.tick && (t2_tk.count == t2_compare_reg_a);
    assign t2_match[1] = t2_tk.tick && (t2_tk.count == t2_compare_reg_b);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            t2_compare_reg_a <= cpwm_pkg::COMPARE_RESET;
            t2_compare_reg_b <= cpwm_pkg::COMPARE_RESET;
        end else begin
            if (T2_CMP_WR_A) begin
                t2_compare_reg_a <= T2_CMP_DATA;
            end
            if (T2_CMP_WR_B) begin
                t2_compare_reg_b <= T2_CMP_DATA;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < 2; i++) begin
            if (!RST_N) begin
                T2_PIN[i] <= 1'b0;
            end else if (T2_MODE[i] == cpwm_pkg::CPWM_MODE1) begin
                if (t2_match[i]) begin
                    T2_PIN[i] <= T2_PORT_LATCH[i];
                end
            end else if (t2_tk.overflow) begin
                T2_PIN[i] <= 1'b0;
            end else if (t2_match[i]) begin
                T2_PIN[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < 2; i++) begin
            if (!RST_N) begin
                t2_irq[i] <= 1'b0;
            end else if (t2_match[i]) begin
                t2_irq[i] <= 1'b1;
            end else if (T2_IRQ_CLR[i]) begin
                t2_irq[i] <= 1'b0;
            end
        end
    end

    assign COMPARE_IRQ_LINE_A = t2_irq[0];
    assign COMPARE_IRQ_LINE_B = t2_irq[1];

    ////////////////////////////////////////////////////////////////////////////
    // Fast compare bank
    logic [15:0] fast_shadow [cpwm_pkg::NUM_FAST];
    logic [15:0] fast_active [cpwm_pkg::NUM_FAST];
    logic [7:0]  fast_match;
    logic [7:0]  fast_out;
    logic [7:0]  fast_irq;

    always_comb begin
        for (int i = 0; i < cpwm_pkg::NUM_FAST; i++) begin
            fast_match[i] = FAST_COMPARE_SELECT[i] && ct_tk.tick
                            && (ct_tk.count == fast_active[i]);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < cpwm_pkg::NUM_FAST; i++) begin
            if (!RST_N) begin
                fast_shadow[i] <= cpwm_pkg::COMPARE_RESET;
            end else begin
                if (FAST_WR_HIGH[i]) begin
                    fast_shadow[i][15:8] <= FAST_WR_DATA;
                end
                if (FAST_WR_LOW[i]) begin
                    fast_shadow[i][7:0] <= FAST_WR_DATA;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < cpwm_pkg::NUM_FAST; i++) begin
            if (!RST_N) begin
                fast_active[i] <= cpwm_pkg::COMPARE_RESET;
            end else if (ct_tk.overflow) begin
                fast_active[i] <= fast_shadow[i];
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < cpwm_pkg::NUM_FAST; i++) begin
            if (!RST_N) begin
                fast_out[i] <= 1'b0;
            end else if (!FAST_COMPARE_SELECT[i]) begin
                fast_out[i] <= FAST_PORT_LATCH[i];
            end else if (ct_tk.overflow) begin
                fast_out[i] <= 1'b0;
            end else if (fast_match[i]) begin
                fast_out[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        for (int i = 0; i < cpwm_pkg::NUM_FAST; i++) begin
            if (!RST_N) begin
                fast_irq[i] <= 1'b0;
            end else if (fast_match[i]) begin
                fast_irq[i] <= 1'b1;
            end else if (FAST_IRQ_CLR[i]) begin
                fast_irq[i] <= 1'b0;
            end
        end
    end

    assign FAST_PIN    = fast_out;
    assign FAST_PIN_OE = FAST_COMPARE_OUTPUT_ENABLE;
    assign FAST_IRQ    = fast_irq;

    ////////////////////////////////////////////////////////////////////////////
    // Compare timer overflow request
    logic ct_flag;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ct_flag <= 1'b0;
        end else if (ct_tk.overflow) begin
            ct_flag <= 1'b1;
        end else if (CT_IRQ_CLR) begin
            ct_flag <= 1'b0;
        end
    end

    assign CT_OVF_FLAG = ct_flag;
    assign CT_IRQ      = ct_flag && COMPARE_TIMER_OVERFLOW_IRQ_ENABLE && GLOBAL_IRQ_ENABLE;
    assign CT_COUNT    = ct_tk.count;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_t2_ovf_low;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (t2_tk.overflow && T2_MODE[0] == cpwm_pkg::CPWM_MODE0) |=> !T2_PIN[0];
    endproperty
    a_t2_ovf_low: assert property (p_t2_ovf_low) else $error("mode0 ovf not low");

    property p_fast_match_high;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (fast_match[0] && !ct_tk.overflow && FAST_COMPARE_SELECT[0]) |=> FAST_PIN[0];
    endproperty
    a_fast_match_high: assert property (p_fast_match_high) else $error("no rise");

    property p_mode1_hold;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (T2_MODE[1] == cpwm_pkg::CPWM_MODE1 && !t2_match[1]) |=> $stable(T2_PIN[1]);
    endproperty
    a_mode1_hold: assert property (p_mode1_hold) else $error("mode1 moved");

    property p_mode1_latch;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (T2_MODE[1] == cpwm_pkg::CPWM_MODE1 && t2_match[1])
            |=> T2_PIN[1] == $past(T2_PORT_LATCH[1]);
    endproperty
    a_mode1_latch: assert property (p_mode1_latch) else $error("latch not copied");

    property p_irq_line;
        @(posedge CORE_CLK) disable iff (!RST_N)
        t2_match[0] |=> COMPARE_IRQ_LINE_A;
    endproperty
    a_irq_line: assert property (p_irq_line) else $error("no irq a");

    property p_irq_indep;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (fast_match[1] && !fast_match[0] && !FAST_IRQ_CLR[0])
            |=> fast_irq[0] == $past(fast_irq[0]);
    endproperty
    a_irq_indep: assert property (p_irq_indep) else $error("flags coupled");

    property p_shadow_load;
        @(posedge CORE_CLK) disable iff (!RST_N)
        ct_tk.overflow |=> fast_active[0] == $past(fast_shadow[0]);
    endproperty
    a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

    property p_shadow_hold;
        @(posedge CORE_CLK) disable iff (!RST_N)
        !ct_tk.overflow |=> $stable(fast_active[0]);
    endproperty
    a_shadow_hold: assert property (p_shadow_hold) else $error("early load");

    property p_ovf_flag;
        @(posedge CORE_CLK) disable iff (!RST_N)
        ct_tk.overflow |=> CT_OVF_FLAG;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("no ovf flag");

    property p_irq_gate;
        @(posedge CORE_CLK) disable iff (!RST_N)
        CT_IRQ |-> (GLOBAL_IRQ_ENABLE && COMPARE_TIMER_OVERFLOW_IRQ_ENABLE && CT_OVF_FLAG);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("ungated irq");

    property p_t2_match_high;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (t2_match[0] && !t2_tk.overflow && T2_MODE[0] == cpwm_pkg::CPWM_MODE0) |=> T2_PIN[0];
    endproperty
    a_t2_match_high: assert property (p_t2_match_high) else $error("mode0 no rise");

    property p_irq_line_b;
        @(posedge CORE_CLK) disable iff (!RST_N)
        t2_match[1] |=> COMPARE_IRQ_LINE_B;
    endproperty
    a_irq_line_b: assert property (p_irq_line_b) else $error("no irq b");

    property p_t2_irq_clear;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (T2_IRQ_CLR[0] && !t2_match[0]) |=> !COMPARE_IRQ_LINE_A;
    endproperty
    a_t2_irq_clear: assert property (p_t2_irq_clear) else $error("irq a stuck");

    property p_fast_all_low;
        @(posedge CORE_CLK) disable iff (!RST_N)
        ct_tk.overflow |=> (FAST_PIN & $past(FAST_COMPARE_SELECT)) == 8'h00;
    endproperty
    a_fast_all_low: assert property (p_fast_all_low) else $error("ovf not all low");

    property p_fast_irq_set;
        @(posedge CORE_CLK) disable iff (!RST_N)
        fast_match[0] |=> FAST_IRQ[0];
    endproperty
    a_fast_irq_set: assert property (p_fast_irq_set) else $error("no fast irq");

    property p_fast_irq_clear;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (FAST_IRQ_CLR[0] && !fast_match[0]) |=> !FAST_IRQ[0];
    endproperty
    a_fast_irq_clear: assert property (p_fast_irq_clear) else $error("fast irq stuck");

    property p_unsel_latch;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (RST_N && !FAST_COMPARE_SELECT[2]) |=> FAST_PIN[2] == $past(FAST_PORT_LATCH[2]);
    endproperty
    a_unsel_latch: assert property (p_unsel_latch) else $error("latch not on pin");

    property p_shadow_load_b;
        @(posedge CORE_CLK) disable iff (!RST_N)
        ct_tk.overflow |=> fast_active[1] == $past(fast_shadow[1]);
    endproperty
    a_shadow_load_b: assert property (p_shadow_load_b) else $error("shadow 1 not loaded");

    property p_ovf_clear;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CT_IRQ_CLR && !ct_tk.overflow) |=> !CT_OVF_FLAG;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("ovf flag stuck");

    property p_ovf_sticky;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (CT_OVF_FLAG && !CT_IRQ_CLR) |=> CT_OVF_FLAG;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("ovf flag lost");
endmodule : cpwm_unit

/* bench/cpwm_rc_load.sv */
// RC low-pass load on one compare output pin
// Assumes pin and enable are sampled on the core clock
module cpwm_rc_load (
    input  wire logic       clk,
    input  wire logic       pin,
    input  wire logic       oe,
    output logic      [7:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    initial level = 8'h00;
    // Charge while driven high, discharge otherwise
    always @(posedge clk) begin
        if (oe && pin && level != 8'hff) level <= level + 8'h01;
        else if (!(oe && pin) && level != 8'h00) level <= level - 8'h01;
    end
endmodule : cpwm_rc_load

/* bench/tb.sv */
// Self-checking bench for the compare/PWM unit
// Assumes the design package, interface and modules are compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CORE_CLK, RST_N, T2_RUN, T2_CMP_WR_A, T2_CMP_WR_B, CT_RUN, CT_IRQ_CLR;
    logic        COMPARE_TIMER_OVERFLOW_IRQ_ENABLE, GLOBAL_IRQ_ENABLE, CT_OVF_FLAG, CT_IRQ;
    logic        COMPARE_IRQ_LINE_A, COMPARE_IRQ_LINE_B, mon_cnt, mon_pin, hit;
    logic [1:0]  T2_MODE, T2_PORT_LATCH, T2_IRQ_CLR, T2_PIN;
    logic [2:0]  COMPARE_TIMER_CONTROL;
    logic [7:0]  COMPARE_TIMER_RELOAD_HIGH, COMPARE_TIMER_RELOAD_LOW, FAST_COMPARE_SELECT;
    logic [7:0]  FAST_COMPARE_OUTPUT_ENABLE, FAST_PORT_LATCH, FAST_WR_HIGH, FAST_WR_LOW;
    logic [7:0]  FAST_WR_DATA, FAST_IRQ_CLR, FAST_PIN, FAST_PIN_OE, FAST_IRQ, rc_level;
    logic [7:0]  pin_m, irq_m, p_lat, p_clr, p_wh, p_wl, p_d, m;
    logic [15:0] T2_CMP_DATA, CT_COUNT, pc, target, v;
    logic [15:0] sh [8];
    logic [15:0] act [8];
    logic        ovf_m, p_cclr, en_m;
    logic [31:0] lf;
    int          bad_count, comparisons, cyc, ta, g;

    cpwm_unit u_cpwm_unit (.CORE_CLK, .RST_N, .T2_RUN, .T2_MODE, .T2_CMP_WR_A, .T2_CMP_WR_B,
        .T2_CMP_DATA, .T2_PORT_LATCH, .T2_IRQ_CLR, .CT_RUN, .COMPARE_TIMER_CONTROL,
        .COMPARE_TIMER_RELOAD_HIGH, .COMPARE_TIMER_RELOAD_LOW, .FAST_COMPARE_SELECT,
        .FAST_COMPARE_OUTPUT_ENABLE, .FAST_PORT_LATCH, .FAST_WR_HIGH, .FAST_WR_LOW,
        .FAST_WR_DATA, .FAST_IRQ_CLR, .COMPARE_TIMER_OVERFLOW_IRQ_ENABLE, .GLOBAL_IRQ_ENABLE,
        .CT_IRQ_CLR, .T2_PIN, .FAST_PIN, .FAST_PIN_OE, .COMPARE_IRQ_LINE_A,
        .COMPARE_IRQ_LINE_B, .FAST_IRQ, .CT_OVF_FLAG, .CT_IRQ, .CT_COUNT);
    cpwm_rc_load u_cpwm_rc_load (.clk(CORE_CLK), .pin(FAST_PIN[0]), .oe(FAST_PIN_OE[0]),
        .level(rc_level));

    ////////////////////////////////////////////////////////////////////////////////
    initial CORE_CLK = 1'b0;
    always #5 CORE_CLK = ~CORE_CLK;
    initial cyc = 0;
    always @(posedge CORE_CLK) cyc <= cyc + 1;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction : lfsr_next

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish;
        if (bad_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic wait_on(input int which, input int bound);
        int   k;
        logic w;
        k = 0;
        w = 1'b0;
        while (w !== 1'b1 && k < bound) begin
            @(posedge CORE_CLK);
            #1;
            k++;
            case (which)
                0: w = COMPARE_IRQ_LINE_A;
                1: w = COMPARE_IRQ_LINE_B;
                2: w = CT_OVF_FLAG;
                default: w = (CT_COUNT === target);
            endcase
        end
        if (w !== 1'b1) begin
            bad_count++;
            $display("[FAIL] wait %0d expected 1 seen 0", which);
            tally_and_finish();
        end
    endtask : wait_on

    task automatic gap(output int n);
        logic [15:0] c0;
        c0 = CT_COUNT;
        n = 0;
        while (CT_COUNT === c0 && n < 600) begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        if (n >= 600) begin
            bad_count++;
            $display("[FAIL] tick_gap expected change seen none");
            tally_and_finish();
        end
    endtask : gap

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model of the fast bank, judged between edges
    always @(negedge CORE_CLK) begin
        if (!RST_N) begin
            pc = 16'h0000;
            pin_m = 8'h00;
            irq_m = 8'h00;
            ovf_m = 1'b0;
            for (int n = 0; n < 8; n++) begin
                sh[n] = 16'h0000;
                act[n] = 16'h0000;
            end
        end else begin
            if (mon_cnt) begin
                chk("ct_count", 32'(&pc ? 16'hff00 : pc + 16'h0001), 32'(CT_COUNT));
                ovf_m = (pc == 16'hffff) | (ovf_m & ~p_cclr);
                for (int n = 0; n < 8; n++) begin
                    hit = FAST_COMPARE_SELECT[n] && (pc == act[n]);
                    if (!FAST_COMPARE_SELECT[n]) pin_m[n] = p_lat[n];
                    else if (pc == 16'hffff) pin_m[n] = 1'b0;
                    else if (hit) pin_m[n] = 1'b1;
                    irq_m[n] = hit | (irq_m[n] & ~p_clr[n]);
                    if (pc == 16'hffff) act[n] = sh[n];
                end
            end
            for (int n = 0; n < 8; n++) begin
                if (p_wh[n]) sh[n][15:8] = p_d;
                if (p_wl[n]) sh[n][7:0] = p_d;
            end
            if (mon_pin) begin
                chk("fast_pin", 32'(pin_m), 32'(FAST_PIN));
                en_m = COMPARE_TIMER_OVERFLOW_IRQ_ENABLE & GLOBAL_IRQ_ENABLE;
                chk("fast_irq", 32'(irq_m), 32'(FAST_IRQ));
                chk("ct_flag", 32'(ovf_m), 32'(CT_OVF_FLAG));
                chk("ct_irq", 32'(ovf_m & en_m), 32'(CT_IRQ));
                chk("fast_oe", 32'(FAST_COMPARE_OUTPUT_ENABLE), 32'(FAST_PIN_OE));
            end
            pc = CT_COUNT;
        end
        {p_lat, p_clr, p_wh} = {FAST_PORT_LATCH, FAST_IRQ_CLR, FAST_WR_HIGH};
        {p_wl, p_d} = {FAST_WR_LOW, FAST_WR_DATA};
        p_cclr = CT_IRQ_CLR;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        bad_count = 0;
        comparisons = 0;
        lf = 32'h489051bb;
        {mon_cnt, mon_pin, RST_N, T2_RUN, CT_RUN, CT_IRQ_CLR, T2_CMP_WR_A, T2_CMP_WR_B} = 8'h00;
        {FAST_WR_HIGH, FAST_WR_LOW, FAST_WR_DATA, FAST_IRQ_CLR, T2_IRQ_CLR} = 34'h0;
        {COMPARE_TIMER_OVERFLOW_IRQ_ENABLE, GLOBAL_IRQ_ENABLE} = 2'b11;
        {T2_MODE, T2_PORT_LATCH, T2_CMP_DATA, COMPARE_TIMER_CONTROL} = {2'b10, 2'b10, 16'h0010, 3'h0};
        {COMPARE_TIMER_RELOAD_HIGH, COMPARE_TIMER_RELOAD_LOW} = 16'hff00;
        lf = lfsr_next(lf);
        {FAST_COMPARE_SELECT, FAST_COMPARE_OUTPUT_ENABLE, FAST_PORT_LATCH} = lf[23:0] | 24'h030000;
        repeat (8) @(posedge CORE_CLK);
        #1;
        chk("reset_out", 32'h0, 32'({T2_PIN, FAST_PIN, FAST_IRQ, CT_OVF_FLAG}));
        chk("reset_count", 32'h0, 32'(CT_COUNT));
        @(posedge CORE_CLK) RST_N <= 1'b1;
        T2_CMP_WR_A <= 1'b1;
        FAST_WR_HIGH <= 8'hff;
        FAST_WR_DATA <= 8'hff;
        @(posedge CORE_CLK) {T2_CMP_WR_A, T2_CMP_WR_B, T2_CMP_DATA} <= {2'b01, 16'h0020};
        FAST_WR_HIGH <= 8'h00;
        FAST_WR_LOW <= 8'hff;
        FAST_WR_DATA <= lf[31:24];
        @(posedge CORE_CLK) {T2_CMP_WR_B, FAST_WR_LOW, T2_RUN, CT_RUN} <= {9'h000, 2'b11};
        target = 16'h0004;
        wait_on(3, 50);
        mon_cnt = 1'b1;
        wait_on(0, 100);
        ta = cyc;
        chk("t2_pin_a", 32'h1, 32'(T2_PIN[0]));
        @(posedge CORE_CLK) T2_IRQ_CLR <= 2'b01;
        @(posedge CORE_CLK) T2_IRQ_CLR <= 2'b00;
        wait_on(1, 100);
        chk("t2_gap_ab", 32'h10, 32'(cyc - ta));
        chk("t2_pin_b", 32'h1, 32'(T2_PIN[1]));
        @(posedge CORE_CLK) {T2_IRQ_CLR, T2_PORT_LATCH} <= 4'h8;
        @(posedge CORE_CLK) T2_IRQ_CLR <= 2'b00;
        while (cyc < ta + 65528) @(posedge CORE_CLK);
        #1;
        chk("t2_pins_ovf", 32'h2, 32'(T2_PIN));
        wait_on(0, 100);
        chk("t2_period", 32'(65536), 32'(cyc - ta));
        wait_on(1, 100);
        chk("t2_pin_b2", 32'h0, 32'(T2_PIN[1]));
        wait_on(2, 70000);
        @(posedge CORE_CLK) {FAST_IRQ_CLR, CT_IRQ_CLR} <= 9'h1ff;
        @(posedge CORE_CLK) {FAST_IRQ_CLR, CT_IRQ_CLR} <= 9'h000;
        @(posedge CORE_CLK) mon_pin = 1'b1;
        for (int k = 0; k < 30; k++) begin
            target = 16'hff40;
            wait_on(3, 300);
            lf = lfsr_next(lf);
            v = (k == 0) ? 16'hffff : (k == 1) ? 16'hff00 : {lf[31] ? 8'hff : lf[30:23], lf[7:0]};
            m = (k < 2) ? 8'h01 : 8'h01 << lf[10:8];
            @(posedge CORE_CLK) {FAST_WR_HIGH, FAST_WR_DATA} <= {m, v[15:8]};
            @(posedge CORE_CLK) {FAST_WR_HIGH, FAST_WR_LOW, FAST_WR_DATA} <= {8'h00, m, v[7:0]};
            {FAST_PORT_LATCH, FAST_COMPARE_OUTPUT_ENABLE, FAST_IRQ_CLR} <= lf[23:0];
            {CT_IRQ_CLR, COMPARE_TIMER_OVERFLOW_IRQ_ENABLE, GLOBAL_IRQ_ENABLE} <= lf[26:24] | 3'h3;
            if (lf[27]) {COMPARE_TIMER_OVERFLOW_IRQ_ENABLE, GLOBAL_IRQ_ENABLE} <= lf[29:28];
            @(posedge CORE_CLK) {FAST_WR_LOW, FAST_IRQ_CLR, CT_IRQ_CLR} <= 17'h0;
        end
        target = 16'hff40;
        wait_on(3, 300);
        @(posedge CORE_CLK) {FAST_WR_HIGH, FAST_WR_DATA, FAST_COMPARE_OUTPUT_ENABLE} <= 24'h01ff01;
        @(posedge CORE_CLK) {FAST_WR_HIGH, FAST_WR_LOW, FAST_WR_DATA} <= 24'h000100;
        @(posedge CORE_CLK) FAST_WR_LOW <= 8'h00;
        repeat (3) wait_on(3, 300);
        chk("rc_level", 32'hff, 32'(rc_level));
        {mon_cnt, mon_pin} = 2'b00;
        for (int s = 0; s < 8; s++) begin
            @(posedge CORE_CLK) COMPARE_TIMER_CONTROL <= 3'(s);
            repeat (3) gap(g);
            chk("tick_gap", 32'(1 << s), 32'(g));
        end
        tally_and_finish();
    end
endmodule : tb
